// ===== hw/reset_and_watchdog_sequencer.sv
// reset sequencing, reset cause flags and watchdog for the controller core
//
// What this block does
// [R01] Any reset returns registers to defaults, USB addresses zero, interrupts off.
// [R02] Any reset loads program and data stack pointers with zero.
// [R03] Firmware should move the data stack below the USB buffers at E8.
// [R04] Reset cause kept in status port FF: bit4 power-on, bit5 bus, bit6 watchdog.
// [R05] After power-on or watchdog reset, fetching starts at address zero.
// [R06] Reset entry pushes nothing on the program stack.
// [R07] Power-on reset sets the power-on flag, bit 4.
// [R08] Power-on forces ports to input; port 3 bit 7 picks the path.
// [R09] Strap high and lines idle after power-on: suspend until bus activity.
// [R10] Leaving suspend with strap high runs a 128 us start-up delay.
// [R11] Strap low after power-on runs a 128 ms start-up delay.
// [R12] Strap high: short delay; else power-on flag picks long, else short.
// [R13] Firmware should clear the power-on flag before entering suspend.
// [R14] Watchdog reset when counter MSB goes low to high.
// [R15] Watchdog reset sets status bit 6.
// [R16] Two-bit watchdog counter advances on timer bit 11 ticks.
// [R17] Any write to port 26 clears the watchdog counter.
// [R18] Firmware must clear the watchdog more often than every 8.192 ms.
// [R19] Watchdog reset held 2.048 ms, then fetching resumes at zero.
// [R20] Watchdog reset disables USB transmit until address MSB is set again.
// [R21] External 6 MHz reference needs the oscillator output pin left open.
// [R22] USB bus reset is an interrupt through vector 0002, not a restart.
// [R23] Cause flags hold until firmware clears them; power-on clears bits 5 and 6, other causes only add.
`timescale 1ns/100ps

module reset_and_watchdog_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned SHORT_DELAY = SHORT_DELAY_CYCLES,
    parameter int unsigned LONG_DELAY  = LONG_DELAY_CYCLES,
    parameter int unsigned WDR_HOLD    = WDR_HOLD_CYCLES
) (
    // clock and power-on reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // processor i/o port access
    input  wire logic [7:0]             io_addr,
    input  wire logic [7:0]             io_wdata,
    input  wire logic                   io_wr,
    input  wire logic                   io_rd,
    output logic      [7:0]             io_rdata,
    // free-running timer and usb engine
    input  wire logic [TIMER_WIDTH-1:0] free_timer,
    input  wire logic                   usb_bus_reset,
    input  wire logic                   usb_addr_msb,
    output logic                        usb_tx_enable,
    // pins
    input  wire logic                   strap_pin,
    input  wire logic                   usb_dp_pin,
    input  wire logic                   usb_dm_pin,
    // core control
    output logic                        core_reset,
    output logic                        cpu_hold,
    output logic                        gpio_force_input,
    output logic                        suspend,
    output logic                        entry_valid,
    output logic      [13:0]            entry_addr,
    output logic                        entry_push,
    output logic      [7:0]             program_stack_ptr,
    output logic      [7:0]             data_stack_ptr
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // bit 2 strap, bit 1 d+, bit 0 d-
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_c;
    logic [2:0] pin_state;
    logic       strap_high;
    logic       line_idle;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_a    <= 3'h0;
            sync_b    <= 3'h0;
            sync_c    <= 3'h0;
            pin_state <= 3'h0;
        end else begin
            sync_a <= {strap_pin, usb_dp_pin, usb_dm_pin};
            sync_b <= sync_a;
            sync_c <= sync_b;
            for (int i = 0; i < 3; i++) begin
                if (sync_b[i] == sync_c[i]) begin
                    pin_state[i] <= sync_c[i];
                end
            end
        end
    end

    assign strap_high = pin_state[2];
    // low-speed idle (j): d- high, d+ low
    assign line_idle  = pin_state[0] & ~pin_state[1];

    // ------------------------------------------------------------
    // start-up delay choice
    // ------------------------------------------------------------
    // returns the last count of the chosen delay
    function automatic logic [COUNT_WIDTH-1:0] startup_last(
        input logic strap,
        input logic por_seen
    );
        logic [COUNT_WIDTH-1:0] cycles;
        cycles = COUNT_WIDTH'(SHORT_DELAY);
        // [R12] strap wins, then power-on flag
        if (!strap && por_seen) begin
            cycles = COUNT_WIDTH'(LONG_DELAY);
        end
        return cycles - COUNT_WIDTH'(1);
    endfunction : startup_last

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    seq_state_type             state;
    logic [7:0]                status;
    logic                      timer_bit_prev;
    logic                      tick;
    logic                      wd_clear;
    logic [WATCHDOG_WIDTH-1:0] watchdog;
    logic                      wdr_fire;
    logic                      in_run;

    assign in_run = (state == ST_RUN);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timer_bit_prev <= 1'b0;
        end else begin
            timer_bit_prev <= free_timer[WATCHDOG_TICK_BIT];
        end
    end

    // [R16] rising edge of timer bit 11 is the 4.096 ms tick
    assign tick     = free_timer[WATCHDOG_TICK_BIT] & ~timer_bit_prev;
    // [R17] any value written to the clear port
    assign wd_clear = in_run & io_wr & (io_addr == WATCHDOG_CLEAR_ADDR);
    // [R14] msb low to high on the 01 -> 10 step
    assign wdr_fire = in_run & tick & ~wd_clear
                    & (watchdog == WATCHDOG_WIDTH'(1));

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            watchdog <= '0;
        end else if (!in_run || wd_clear) begin
            // [R17] clear beats a same-cycle tick
            watchdog <= '0;
        end else if (tick) begin
            // [R16] two-bit count, cleared in the hold after reaching 10
            watchdog <= watchdog + WATCHDOG_WIDTH'(1);
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    logic [COUNT_WIDTH-1:0] delay_cnt;
    logic [2:0]             settle_cnt;
    logic                   por_path;
    logic                   pins_settled;

    // synchronisers clear on reset, so pin_state first holds a pin
    // after the fourth edge; the strap decision waits one more
    assign pins_settled = (settle_cnt == SETTLE_LAST);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state      <= ST_SETTLE;
            delay_cnt  <= '0;
            settle_cnt <= 3'h0;
            por_path   <= 1'b1;
        end else begin
            unique case (state)
                // synchronisers fill before the strap is trusted
                ST_SETTLE: begin
                    settle_cnt <= settle_cnt + 3'h1;
                    if (pins_settled) begin
                        // [R09] strap high and idle lines: suspend
                        if (strap_high && line_idle) begin
                            state <= ST_SUSPEND;
                        end else begin
                            // [R11] strap low takes the long delay
                            state     <= ST_STARTUP;
                            delay_cnt <= startup_last(strap_high,
                                                      status[POWER_ON_BIT]);
                        end
                    end
                end
                ST_SUSPEND: begin
                    // [R09] bus reset, k or se0 all leave idle
                    if (!line_idle) begin
                        // [R10] strap still high gives 128 us
                        state     <= ST_STARTUP;
                        delay_cnt <= startup_last(strap_high,
                                                  status[POWER_ON_BIT]);
                    end
                end
                ST_STARTUP: begin
                    delay_cnt <= delay_cnt - COUNT_WIDTH'(1);
                    if (delay_cnt == '0) begin
                        state    <= ST_RUN;
                        por_path <= 1'b0;
                    end
                end
                ST_RUN: begin
                    if (wdr_fire) begin
                        // [R19] hold for 2.048 ms
                        state     <= ST_WDR_HOLD;
                        delay_cnt <= COUNT_WIDTH'(WDR_HOLD) - COUNT_WIDTH'(1);
                    end
                end
                ST_WDR_HOLD: begin
                    delay_cnt <= delay_cnt - COUNT_WIDTH'(1);
                    if (delay_cnt == '0) begin
                        state <= ST_RUN;
                    end
                end
                // unused codes fall back to a fresh settle
                default: begin
                    state <= ST_SETTLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // core control outputs
    // ------------------------------------------------------------
    // [R01] registers, usb addresses and interrupt enables held at default
    assign core_reset       = ~in_run;
    assign cpu_hold         = ~in_run;
    // [R08] ports stay inputs through the power-on path
    assign gpio_force_input = por_path;
    assign suspend          = (state == ST_SUSPEND);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            program_stack_ptr <= STACK_PTR_RESET;
            data_stack_ptr    <= STACK_PTR_RESET;
        end else if (!in_run) begin
            // [R02] both stacks restart at zero
            program_stack_ptr <= STACK_PTR_RESET;
            data_stack_ptr    <= STACK_PTR_RESET;
        end
    end

    // ------------------------------------------------------------
    // entry requests
    // ------------------------------------------------------------
    logic run_prev;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            run_prev <= 1'b0;
        end else begin
            run_prev <= in_run;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            entry_valid <= 1'b0;
            entry_addr  <= RESET_VECTOR;
            entry_push  <= 1'b0;
        end else if (in_run && !run_prev) begin
            // [R05] fetch restarts at zero
            entry_valid <= 1'b1;
            entry_addr  <= RESET_VECTOR;
            // [R06] nothing pushed on reset entry
            entry_push  <= 1'b0;
        end else if (in_run && usb_bus_reset && !wdr_fire) begin
            // [R22] bus reset enters through its vector
            entry_valid <= 1'b1;
            entry_addr  <= USB_RESET_VECTOR;
            entry_push  <= 1'b1;
        end else begin
            entry_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // usb transmitter gate
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            usb_tx_enable <= 1'b0;
        end else if (!in_run || wdr_fire) begin
            // [R20] cleared address keeps the transmitter off
            usb_tx_enable <= 1'b0;
        end else if (usb_addr_msb) begin
            // [R20] re-enabled by the address msb
            usb_tx_enable <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // processor status port
    // ------------------------------------------------------------
    logic       status_wr;
    logic [7:0] next_status;

    assign status_wr = in_run & io_wr & (io_addr == PROC_STATUS_ADDR);

    always_comb begin
        next_status = status;
        // [R23] writing zero clears a flag, one keeps it
        if (status_wr) begin
            next_status = status & (io_wdata | ~FLAG_MASK);
        end
        // [R15] watchdog flag, set beats clear
        if (wdr_fire) begin
            next_status[WATCHDOG_BIT] = 1'b1;
        end
        // [R04] bus reset flag, set beats clear
        if (usb_bus_reset) begin
            next_status[USB_RESET_BIT] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            // [R07] power-on flag set, others clear
            status <= PROC_STATUS_RESET;
        end else begin
            status <= next_status & FLAG_MASK;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            io_rdata <= 8'h00;
        end else if (io_rd && io_addr == PROC_STATUS_ADDR) begin
            // [R04] firmware reads the cause flags
            io_rdata <= status;
        end else begin
            io_rdata <= 8'h00;
        end
    end

endmodule : reset_and_watchdog_sequencer

// ===== hw/reset_seq_pkg.sv
// constants and types for the reset and watchdog sequencer
package reset_seq_pkg;

    // ------------------------------------------------------------
    // i/o port map
    // ------------------------------------------------------------
    localparam logic [7:0]  WATCHDOG_CLEAR_ADDR = 8'h26;
    localparam logic [7:0]  PROC_STATUS_ADDR    = 8'hFF;

    // ------------------------------------------------------------
    // processor status fields
    // ------------------------------------------------------------
    localparam int          POWER_ON_BIT        = 4;
    localparam int          USB_RESET_BIT       = 5;
    localparam int          WATCHDOG_BIT        = 6;
    localparam logic [7:0]  FLAG_MASK           = 8'h70;
    localparam logic [7:0]  PROC_STATUS_RESET   = 8'h10;

    // ------------------------------------------------------------
    // entry points and stack
    // ------------------------------------------------------------
    localparam logic [13:0] RESET_VECTOR        = 14'h0000;
    localparam logic [13:0] USB_RESET_VECTOR    = 14'h0002;
    localparam logic [7:0]  STACK_PTR_RESET     = 8'h00;
    localparam logic [7:0]  USB_BUFFER_BASE     = 8'hE8;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ              = 50_000_000;
    localparam int          SHORT_DELAY_US      = 128;
    localparam int          LONG_DELAY_MS       = 128;
    localparam int          WDR_HOLD_US         = 2048;
    localparam int          SHORT_DELAY_CYCLES  = (CLK_HZ / 1_000_000) * SHORT_DELAY_US;
    localparam int          LONG_DELAY_CYCLES   = (CLK_HZ / 1_000) * LONG_DELAY_MS;
    localparam int          WDR_HOLD_CYCLES     = (CLK_HZ / 1_000_000) * WDR_HOLD_US;
    localparam int          COUNT_WIDTH         = 23;
    localparam logic [2:0]  SETTLE_LAST         = 3'h4;

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    localparam int          TIMER_WIDTH         = 12;
    localparam int          WATCHDOG_TICK_BIT   = 11;
    localparam int          WATCHDOG_WIDTH      = 2;

    typedef enum logic [2:0] {
        ST_SETTLE,
        ST_SUSPEND,
        ST_STARTUP,
        ST_RUN,
        ST_WDR_HOLD
    } seq_state_type;

endpackage : reset_seq_pkg

// ===== sim/reset_seq_props.sv
// concurrent checks on the reset and watchdog sequencer ports
`timescale 1ns/100ps

module reset_seq_props
    import reset_seq_pkg::*;
#(
    parameter int unsigned SHORT_DELAY = 8,
    parameter int unsigned LONG_DELAY  = 20,
    parameter int unsigned WDR_HOLD    = 12
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // i/o port
    input wire logic [7:0]  io_addr,
    input wire logic        io_rd,
    input wire logic [7:0]  io_rdata,
    // usb engine
    input wire logic        usb_addr_msb,
    input wire logic        usb_tx_enable,
    // core control
    input wire logic        core_reset,
    input wire logic        cpu_hold,
    input wire logic        gpio_force_input,
    input wire logic        suspend,
    input wire logic        entry_valid,
    input wire logic [13:0] entry_addr,
    input wire logic        entry_push,
    input wire logic [7:0]  program_stack_ptr,
    input wire logic [7:0]  data_stack_ptr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // reset hold and entry
    // ------------------------------------------------------------
    chk_stack_zero: assert property (core_reset |-> (program_stack_ptr == 8'h00) && (data_stack_ptr == 8'h00))
        else $error("stack pointers not zero while held");
    chk_hold_same: assert property (cpu_hold == core_reset)
        else $error("cpu hold differs from core reset");
    chk_entry_zero: assert property ($fell(core_reset) |=> entry_valid && entry_addr == RESET_VECTOR && !entry_push)
        else $error("no reset entry after release");
    chk_bus_vector: assert property (entry_valid && entry_push |-> entry_addr == USB_RESET_VECTOR)
        else $error("bus reset entry at wrong address");
    chk_hold_min: assert property ($rose(core_reset) |-> !usb_tx_enable ##0 core_reset [*8])
        else $error("watchdog hold too short");
    chk_tx_msb: assert property ($rose(usb_tx_enable) |-> $past(usb_addr_msb))
        else $error("transmitter enabled without address msb");
    chk_tx_off_hold: assert property (core_reset |-> !usb_tx_enable)
        else $error("transmitter on during reset");
    chk_gpio_input: assert property (gpio_force_input |-> core_reset)
        else $error("ports forced to input while running");
    chk_suspend_held: assert property (suspend |-> core_reset && !entry_valid)
        else $error("processor free during suspend");
    chk_read_other: assert property (io_rd && io_addr != PROC_STATUS_ADDR |=> io_rdata == 8'h00)
        else $error("unmapped or write-only read not zero");
    chk_read_mask: assert property ((io_rdata & ~FLAG_MASK) == 8'h00)
        else $error("status bits outside flags set");
endmodule : reset_seq_props

bind reset_and_watchdog_sequencer reset_seq_props #(
    .SHORT_DELAY(SHORT_DELAY), .LONG_DELAY(LONG_DELAY), .WDR_HOLD(WDR_HOLD)
) reset_seq_props_i (
    .sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_rd(io_rd), .io_rdata(io_rdata),
    .usb_addr_msb(usb_addr_msb), .usb_tx_enable(usb_tx_enable), .core_reset(core_reset),
    .cpu_hold(cpu_hold), .gpio_force_input(gpio_force_input), .suspend(suspend),
    .entry_valid(entry_valid), .entry_addr(entry_addr), .entry_push(entry_push),
    .program_stack_ptr(program_stack_ptr), .data_stack_ptr(data_stack_ptr)
);

// ===== sim/usb_host_model.sv
// usb host line states and strap pin facing the sequencer
`timescale 1ns/100ps

module usb_host_model (
    // commands from the bench
    input  wire logic       strap_high,
    input  wire logic [1:0] line_state,
    // pins
    output logic            strap_pin,
    output logic            usb_dp_pin,
    output logic            usb_dm_pin
);
    assign strap_pin = strap_high;
    always_comb begin
        case (line_state)
            2'h1: {usb_dp_pin, usb_dm_pin} = 2'h0;
            2'h2: {usb_dp_pin, usb_dm_pin} = 2'h2;
            default: {usb_dp_pin, usb_dm_pin} = 2'h1;
        endcase
    end
endmodule : usb_host_model

// ===== sim/reset_and_watchdog_sequencer_bench.sv
// self-checking bench for the reset and watchdog sequencer
`timescale 1ns/100ps

module reset_and_watchdog_sequencer_bench;
    import reset_seq_pkg::*;
    localparam int SD = 8, LD = 20, WH = 12;
    logic sys_clk, rst, io_wr, io_rd, usb_bus_reset, usb_addr_msb, strap_high;
    logic strap_pin, usb_dp_pin, usb_dm_pin, usb_tx_enable, core_reset, cpu_hold;
    logic gpio_force_input, suspend, entry_valid, entry_push;
    logic [7:0] io_addr, io_wdata, io_rdata, program_stack_ptr, data_stack_ptr;
    logic [TIMER_WIDTH-1:0] free_timer;
    logic [1:0] line_state;
    logic [13:0] entry_addr;
    int fail_count = 0, samples_checked = 0, cycles = 0, n;

    reset_and_watchdog_sequencer #(.SHORT_DELAY(SD), .LONG_DELAY(LD), .WDR_HOLD(WH))
    reset_and_watchdog_sequencer_i (.sys_clk(sys_clk), .rst(rst), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
        .free_timer(free_timer), .usb_bus_reset(usb_bus_reset), .usb_addr_msb(usb_addr_msb),
        .usb_tx_enable(usb_tx_enable), .strap_pin(strap_pin), .usb_dp_pin(usb_dp_pin),
        .usb_dm_pin(usb_dm_pin), .core_reset(core_reset), .cpu_hold(cpu_hold),
        .gpio_force_input(gpio_force_input), .suspend(suspend), .entry_valid(entry_valid),
        .entry_addr(entry_addr), .entry_push(entry_push),
        .program_stack_ptr(program_stack_ptr), .data_stack_ptr(data_stack_ptr));
    usb_host_model usb_host_model_i (.strap_high(strap_high), .line_state(line_state),
        .strap_pin(strap_pin), .usb_dp_pin(usb_dp_pin), .usb_dm_pin(usb_dm_pin));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask : check
    task automatic give_verdict();
        if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic io_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) {io_addr, io_wdata, io_wr} <= {a, d, 1'b1};
        @(posedge sys_clk) io_wr <= 1'b0;
    endtask : io_write
    task automatic io_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk) {io_addr, io_rd} <= {a, 1'b1};
        @(posedge sys_clk) io_rd <= 1'b0;
        #1 check(16'(io_rdata), 16'(exp));
    endtask : io_read
    task automatic wait_run(output int c);
        c = 0;
        while (core_reset !== 1'b0 && c < 400) begin
            @(posedge sys_clk);
            #1 c++;
        end
    endtask : wait_run
    task automatic do_reset(input logic s);
        @(posedge sys_clk) {rst, strap_high, line_state} <= {1'b1, s, 2'h0};
        repeat (3) @(posedge sys_clk);
        #1 check({program_stack_ptr, data_stack_ptr}, 16'h0000);
        check(16'(data_stack_ptr < USB_BUFFER_BASE), 16'h0001);
        check(16'({core_reset, gpio_force_input, usb_tx_enable}), 16'h0006);
        @(posedge sys_clk) rst <= 1'b0;
    endtask : do_reset
    task automatic timer_tick();
        @(posedge sys_clk) free_timer <= 12'h000;
        repeat (2) @(posedge sys_clk);
        free_timer <= 12'h800;
        repeat (2) @(posedge sys_clk);
    endtask : timer_tick

    // reference drives the clock input only
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {rst, io_wr, io_rd, usb_bus_reset, usb_addr_msb, strap_high} = 6'h20;
        {io_addr, io_wdata, free_timer, line_state} = '0;
        do_reset(1'b0);
        wait_run(n);
        check(16'(n >= LD && n <= LD + 6), 16'h0001);
        @(posedge sys_clk);
        #1 check({entry_valid, entry_push, entry_addr}, {2'h2, RESET_VECTOR});
        check(16'(gpio_force_input), 16'h0000);
        io_read(PROC_STATUS_ADDR, 8'h10);
        io_read(WATCHDOG_CLEAR_ADDR, 8'h00);
        io_read(8'h27, 8'h00);
        io_write(PROC_STATUS_ADDR, 8'h00);
        io_read(PROC_STATUS_ADDR, 8'h00);
        @(posedge sys_clk) usb_bus_reset <= 1'b1;
        @(posedge sys_clk) usb_bus_reset <= 1'b0;
        #1 check({entry_valid, entry_push, entry_addr}, {2'h3, USB_RESET_VECTOR});
        check(16'(core_reset), 16'h0000);
        io_read(PROC_STATUS_ADDR, 8'h20);
        io_write(PROC_STATUS_ADDR, 8'h00);
        @(posedge sys_clk) usb_addr_msb <= 1'b1;
        repeat (3) begin
            timer_tick();
            io_write(WATCHDOG_CLEAR_ADDR, 8'hA5);
        end
        #1 check({14'h0, core_reset, usb_tx_enable}, 16'h0001);
        timer_tick();
        @(posedge sys_clk) {free_timer, usb_addr_msb} <= {12'h000, 1'b0};
        repeat (2) @(posedge sys_clk);
        free_timer <= 12'h800;
        n = 0;
        while (core_reset !== 1'b1 && n < 10) begin
            @(posedge sys_clk);
            #1 n++;
        end
        check(16'(n <= 3), 16'h0001);
        wait_run(n);
        check(16'(n), 16'(WH));
        @(posedge sys_clk);
        #1 check({entry_valid, entry_push, entry_addr}, {2'h2, RESET_VECTOR});
        io_read(PROC_STATUS_ADDR, 8'h40);
        check(16'(usb_tx_enable), 16'h0000);
        @(posedge sys_clk) usb_addr_msb <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 check(16'(usb_tx_enable), 16'h0001);
        do_reset(1'b1);
        repeat (12) @(posedge sys_clk);
        #1 check(16'({suspend, core_reset}), 16'h0003);
        @(posedge sys_clk) line_state <= 2'h1;
        wait_run(n);
        check(16'(n >= SD && n <= SD + 6), 16'h0001);
        io_read(PROC_STATUS_ADDR, 8'h10);
        give_verdict();
    end
endmodule : reset_and_watchdog_sequencer_bench
